// >>> shared/sss_pkg.sv
/*
  Package for the servo stop sequence selector: register offsets, reset
  values, encodings, structs and the synchronizer stage count.
  Assumes an AXI4-Lite master with 32-bit data and one 250 MHz clock.
*/
package sss_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SSS_OFF_LIMIT_SEL  = 8'h00;
  localparam logic [7:0] SSS_OFF_SOFF_SEL   = 8'h04;
  localparam logic [7:0] SSS_OFF_PLOSS_SEL  = 8'h08;
  localparam logic [7:0] SSS_OFF_UV_SEL     = 8'h0c;
  localparam logic [7:0] SSS_OFF_ALARM_SEL  = 8'h10;
  localparam logic [7:0] SSS_OFF_IMM_TORQUE = 8'h14;
  localparam logic [7:0] SSS_OFF_SPEED_THR  = 8'h18;
  localparam logic [7:0] SSS_OFF_APPLY      = 8'h1c;
  localparam logic [7:0] SSS_OFF_STATUS     = 8'h20;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  SSS_RST_LIMIT_SEL  = 2'h0;
  localparam logic [3:0]  SSS_RST_SOFF_SEL   = 4'h0;
  localparam logic [3:0]  SSS_RST_PLOSS_SEL  = 4'h0;
  localparam logic        SSS_RST_UV_SEL     = 1'h1;
  localparam logic [2:0]  SSS_RST_ALARM_SEL  = 3'h0;
  localparam logic [9:0]  SSS_RST_IMM_TORQUE = 10'h000;
  localparam logic [15:0] SSS_RST_SPEED_THR  = 16'h001e;
  localparam logic [1:0]  SSS_LIMIT_SEL_MAX  = 2'h2;
  localparam logic [3:0]  SSS_SEL_MAX        = 4'h9;
  localparam logic [3:0]  SSS_SEL_IMM_DB     = 4'h8;
  localparam logic [3:0]  SSS_SEL_IMM_FREE   = 4'h9;
  localparam int          SSS_SYNC_STAGES    = 2;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SSS_ACT_DBRAKE = 2'b00,
    SSS_ACT_FREE   = 2'b01,
    SSS_ACT_ZERO_T = 2'b10,
    SSS_ACT_IMM    = 2'b11
  } sss_act_t;

  typedef enum logic [1:0] {
    SSS_ST_RUN   = 2'b00,
    SSS_ST_DECEL = 2'b01,
    SSS_ST_STOP  = 2'b10
  } sss_state_t;

  typedef enum logic [1:0] {
    SSS_EV_NONE  = 2'b00,
    SSS_EV_LIMIT = 2'b01,
    SSS_EV_SOFF  = 2'b10,
    SSS_EV_PLOSS = 2'b11
  } sss_event_t;

  typedef struct packed {
    logic [1:0] limit_sel;
    logic [3:0] soff_sel;
    logic [3:0] ploss_sel;
    logic       uv_sel;
    logic [2:0] alarm_sel;
    logic [9:0] imm_torque;
  } sss_cfg_t;

  typedef struct packed {
    sss_act_t act;
    logic     zero_fwd;
    logic     zero_rev;
    logic     err_clear;
    logic     err_hold;
    logic     use_alarm_sel;
    logic     uv_alarm;
    logic     torque_limit_en;
    logic [9:0] torque_limit;
  } sss_cmd_t;

endpackage

// >>> design/sss_top.sv
/*
  Servo stop sequence selector: picks the stop action for travel limit,
  servo off and main power loss, with AXI4-Lite configuration.
  Assumes limit, servo-on and power inputs come from pins, alarm and
  speed from logic on the same clock.
*/
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
// What this block does
// RULE_01: Travel-limit selection applies when either limit input becomes active.
// RULE_02: Limit setting 0: dynamic brake, then zero torque toward limit, hold error.
// RULE_03: Limit setting 1: zero torque toward limit throughout, hold error.
// RULE_04: Limit setting 2: immediate stop, then zero torque, clear error.
// RULE_05: Limit setting 2 bounds deceleration torque by immediate-stop torque.
// RULE_06: Servo-off setting 0-9; odd free-run, even brake; post-stop by bit 1.
// RULE_07: Values 4-7 hold the error counter; others clear it.
// RULE_08: Values 8,9 immediate stop; after, 8 brakes, 9 servo-free.
// RULE_09: Deceleration ends at speed threshold; stop state then sticks.
// RULE_10: Alarm with servo off uses alarm-detection selection.
// RULE_11: Power loss with servo off uses power-loss selection.
// RULE_12: Power-loss setting 0-9 uses the servo-off encoding.
// RULE_13: Alarm with main power off uses alarm-detection selection.
// RULE_14: Power loss, servo on, undervoltage setting 1: raise alarm, alarm stop.
// RULE_15: Held error keeps accumulating; overflow alarm on excess.
// RULE_16: Servo on with retained error lets position control null it.
// RULE_17: Host keeps axis stopped about three minutes after dynamic brake.
// RULE_18: Settings take effect only after power cycle. The speed threshold applies as soon as it is written.
// RULE_19: Undervoltage setting 0: power loss is servo off; resumes on return.
// RULE_20: Immediate-stop torque 0 means normal torque limit.
// RULE_21: Speed threshold compares speed magnitude.
`timescale 1ns/1ps
module sss_top
  import sss_pkg::*;
#(
  parameter int SPEED_W = 16
)(
  input  wire logic                 CLOCK,
  input  wire logic                 RST_N,
  input  wire logic                 POWER_ON_N,
  input  wire logic [7:0]           S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [7:0]           S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  input  wire logic                 FORWARD_LIMIT_INPUT,
  input  wire logic                 REVERSE_LIMIT_INPUT,
  input  wire logic                 SERVO_ON_INPUT,
  input  wire logic                 MAIN_POWER_OK,
  input  wire logic                 ALARM_ACTIVE,
  input  wire logic signed [SPEED_W-1:0] MOTOR_SPEED,
  output sss_pkg::sss_cmd_t         STOP_CMD,
  output sss_pkg::sss_state_t       STOP_STATE
);
  import sss_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    sss_cfg_t   shadow;
    sss_cfg_t   active;
    logic [15:0] speed_thr;
    logic       apply_pend;
    logic       powered;
    logic [SSS_SYNC_STAGES-1:0] s_fwd;
    logic [SSS_SYNC_STAGES-1:0] s_rev;
    logic [SSS_SYNC_STAGES-1:0] s_son;
    logic [SSS_SYNC_STAGES-1:0] s_pwr;
    logic       aw_got;
    logic       w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic       bslverr;
    logic       rvalid;
    logic       rslverr;
    logic [31:0] rdata;
    sss_state_t st;
    sss_event_t ev;
    logic       ev_fwd;
    sss_cmd_t   cmd;
  } sss_top_state_t;

  sss_top_state_t r_q;
  sss_top_state_t r_d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic sel_ok(input logic [7:0] a);
    sel_ok = (a == SSS_OFF_LIMIT_SEL) || (a == SSS_OFF_SOFF_SEL) || (a == SSS_OFF_PLOSS_SEL)
          || (a == SSS_OFF_UV_SEL) || (a == SSS_OFF_ALARM_SEL) || (a == SSS_OFF_IMM_TORQUE)
          || (a == SSS_OFF_SPEED_THR) || (a == SSS_OFF_APPLY) || (a == SSS_OFF_STATUS);
  endfunction

  // Decel action of a servo-off style code
  function automatic sss_act_t decel_act(input logic [3:0] v);
    if (v >= SSS_SEL_IMM_DB)
      decel_act = SSS_ACT_IMM;                                      // see RULE_08
    else if (v[0])
      decel_act = SSS_ACT_FREE;                                     // see RULE_06
    else
      decel_act = SSS_ACT_DBRAKE;
  endfunction

  // Post-stop action of a servo-off style code
  function automatic sss_act_t post_act(input logic [3:0] v);
    if (v == SSS_SEL_IMM_FREE)
      post_act = SSS_ACT_FREE;                                      // see RULE_08
    else if (v == SSS_SEL_IMM_DB)
      post_act = SSS_ACT_DBRAKE;
    else
      post_act = v[1] ? SSS_ACT_FREE : SSS_ACT_DBRAKE;              // see RULE_06
  endfunction

  function automatic logic holds_err(input logic [3:0] v);
    holds_err = (v[3:2] == 2'b01);                                  // see RULE_07
  endfunction

  logic [SPEED_W-1:0] speed_mag;
  logic               slow;
  assign speed_mag = MOTOR_SPEED[SPEED_W-1] ? SPEED_W'(-MOTOR_SPEED) : MOTOR_SPEED; // see RULE_21
  assign slow      = speed_mag <= SPEED_W'(r_q.speed_thr);          // see RULE_09

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic       fwd;
    logic       rev;
    logic       son;
    logic       pwr;
    logic       wr_go;
    logic [3:0] sel;
    logic [9:0] tq;
    sss_event_t ev_now;
    r_d    = r_q;
    fwd    = r_q.s_fwd[SSS_SYNC_STAGES-1];
    rev    = r_q.s_rev[SSS_SYNC_STAGES-1];
    son    = r_q.s_son[SSS_SYNC_STAGES-1];
    pwr    = r_q.s_pwr[SSS_SYNC_STAGES-1];
    sel    = 4'h0;
    tq     = r_q.active.imm_torque;
    ev_now = SSS_EV_NONE;
    wr_go  = 1'b0;

    r_d.s_fwd = {r_q.s_fwd[SSS_SYNC_STAGES-2:0], FORWARD_LIMIT_INPUT};
    r_d.s_rev = {r_q.s_rev[SSS_SYNC_STAGES-2:0], REVERSE_LIMIT_INPUT};
    r_d.s_son = {r_q.s_son[SSS_SYNC_STAGES-2:0], SERVO_ON_INPUT};
    r_d.s_pwr = {r_q.s_pwr[SSS_SYNC_STAGES-2:0], MAIN_POWER_OK};

    // Bus write: address and data in either order
    if (S_AXI_AWVALID && !r_q.aw_got)
    begin
      r_d.aw_got  = 1'b1;
      r_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !r_q.w_got)
    begin
      r_d.w_got  = 1'b1;
      r_d.w_data = S_AXI_WDATA;
      r_d.w_strb = S_AXI_WSTRB;
    end
    wr_go = r_q.aw_got && r_q.w_got && !r_q.bvalid;
    if (wr_go)
    begin
      r_d.aw_got  = 1'b0;
      r_d.w_got   = 1'b0;
      r_d.bvalid  = 1'b1;
      r_d.bslverr = !sel_ok(r_q.aw_addr);
      if (r_q.w_strb[0])
      begin
        // New settings land in a shadow copy, except the speed threshold, which applies at once
        unique case (r_q.aw_addr)
          SSS_OFF_LIMIT_SEL:
            if (r_q.w_data[1:0] <= SSS_LIMIT_SEL_MAX) r_d.shadow.limit_sel = r_q.w_data[1:0];
          SSS_OFF_SOFF_SEL:
            if (r_q.w_data[3:0] <= SSS_SEL_MAX) r_d.shadow.soff_sel = r_q.w_data[3:0];  // see RULE_06
          SSS_OFF_PLOSS_SEL:
            if (r_q.w_data[3:0] <= SSS_SEL_MAX) r_d.shadow.ploss_sel = r_q.w_data[3:0]; // see RULE_12
          SSS_OFF_UV_SEL:     r_d.shadow.uv_sel    = r_q.w_data[0];
          SSS_OFF_ALARM_SEL:  r_d.shadow.alarm_sel = r_q.w_data[2:0];
          SSS_OFF_IMM_TORQUE: r_d.shadow.imm_torque = {r_q.w_strb[1] ? r_q.w_data[9:8] : r_q.shadow.imm_torque[9:8],
                                                       r_q.w_data[7:0]};
          SSS_OFF_SPEED_THR:  r_d.speed_thr[7:0] = r_q.w_data[7:0];
          SSS_OFF_APPLY:      r_d.apply_pend = r_q.w_data[0];
          default:            r_d.bslverr = r_d.bslverr;
        endcase
      end
      if (r_q.w_strb[1] && r_q.aw_addr == SSS_OFF_SPEED_THR)
        r_d.speed_thr[15:8] = r_q.w_data[15:8];
    end
    if (r_q.bvalid && S_AXI_BREADY)
      r_d.bvalid = 1'b0;

    // Bus read
    if (S_AXI_ARVALID && !r_q.rvalid)
    begin
      r_d.rvalid  = 1'b1;
      r_d.rslverr = !sel_ok(S_AXI_ARADDR);
      r_d.rdata   = 32'h0000_0000;
      unique case (S_AXI_ARADDR)
        SSS_OFF_LIMIT_SEL:  r_d.rdata[1:0] = r_q.shadow.limit_sel;
        SSS_OFF_SOFF_SEL:   r_d.rdata[3:0] = r_q.shadow.soff_sel;
        SSS_OFF_PLOSS_SEL:  r_d.rdata[3:0] = r_q.shadow.ploss_sel;
        SSS_OFF_UV_SEL:     r_d.rdata[0]   = r_q.shadow.uv_sel;
        SSS_OFF_ALARM_SEL:  r_d.rdata[2:0] = r_q.shadow.alarm_sel;
        SSS_OFF_IMM_TORQUE: r_d.rdata[9:0] = r_q.shadow.imm_torque;
        SSS_OFF_SPEED_THR:  r_d.rdata[15:0] = r_q.speed_thr;
        SSS_OFF_APPLY:      r_d.rdata[0]   = r_q.apply_pend;
        SSS_OFF_STATUS:     r_d.rdata[7:0] = {r_q.cmd.uv_alarm, r_q.cmd.err_hold, r_q.ev, r_q.st, r_q.cmd.act};
        default:            r_d.rdata = 32'h0000_0000;
      endcase
    end
    if (r_q.rvalid && S_AXI_RREADY)
      r_d.rvalid = 1'b0;

    // Shadow settings reach the selector only at a power cycle
    if (!r_q.powered)
    begin
      r_d.powered    = 1'b1;
      r_d.active     = r_q.shadow;                                  // see RULE_18
      r_d.apply_pend = 1'b0;
    end

    // Event choice: power loss, servo off, then limits
    if (!pwr && !(son && r_q.active.uv_sel))
      ev_now = SSS_EV_PLOSS;                                        // see RULE_11, RULE_19
    else if (!son || !pwr)
      ev_now = SSS_EV_SOFF;
    else if (fwd || rev)
      ev_now = SSS_EV_LIMIT;                                        // see RULE_01

    r_d.cmd.uv_alarm      = !pwr && son && r_q.active.uv_sel;      // see RULE_14
    r_d.cmd.use_alarm_sel = ALARM_ACTIVE || r_d.cmd.uv_alarm;       // see RULE_10, RULE_13

    unique case (r_q.st)
      SSS_ST_RUN:
        if (ev_now != SSS_EV_NONE)
        begin
          r_d.st     = slow ? SSS_ST_STOP : SSS_ST_DECEL;
          r_d.ev     = ev_now;
          r_d.ev_fwd = fwd;
        end
      SSS_ST_DECEL:
        if (ev_now == SSS_EV_NONE)
          r_d.st = SSS_ST_RUN;
        else if (slow)
          r_d.st = SSS_ST_STOP;                                     // see RULE_09
      SSS_ST_STOP:
        if (ev_now == SSS_EV_NONE)
          r_d.st = SSS_ST_RUN;                                      // see RULE_16
      default:
        r_d.st = SSS_ST_RUN;
    endcase
    if (r_q.st != SSS_ST_RUN && ev_now != SSS_EV_NONE && ev_now != r_q.ev)
      r_d.ev = ev_now;

    // Output command from stored event and phase
    r_d.cmd.zero_fwd        = 1'b0;
    r_d.cmd.zero_rev        = 1'b0;
    r_d.cmd.err_clear       = 1'b0;
    r_d.cmd.err_hold        = 1'b0;
    r_d.cmd.torque_limit_en = 1'b0;
    r_d.cmd.act             = SSS_ACT_DBRAKE;
    r_d.cmd.torque_limit    = tq;
    if (r_d.st == SSS_ST_RUN)
      r_d.cmd.act = SSS_ACT_ZERO_T;
    else if (r_d.ev == SSS_EV_LIMIT)
    begin
      r_d.cmd.zero_fwd = r_d.ev_fwd;
      r_d.cmd.zero_rev = !r_d.ev_fwd;
      r_d.cmd.act      = SSS_ACT_ZERO_T;                            // see RULE_02, RULE_03
      if (r_d.st == SSS_ST_DECEL)
        unique case (r_q.active.limit_sel)
          2'h0:    r_d.cmd.act = SSS_ACT_DBRAKE;                    // see RULE_02
          2'h2:    r_d.cmd.act = SSS_ACT_IMM;                       // see RULE_04
          default: r_d.cmd.act = SSS_ACT_ZERO_T;                    // see RULE_03
        endcase
      r_d.cmd.err_clear       = (r_q.active.limit_sel == SSS_LIMIT_SEL_MAX);   // see RULE_04
      r_d.cmd.err_hold        = !r_d.cmd.err_clear;
      r_d.cmd.torque_limit_en = r_d.cmd.err_clear && r_d.st == SSS_ST_DECEL
                                && tq != 10'h000;                   // see RULE_05, RULE_20
    end
    else
    begin
      sel = (r_d.ev == SSS_EV_PLOSS) ? r_q.active.ploss_sel : r_q.active.soff_sel; // see RULE_12
      r_d.cmd.act             = (r_d.st == SSS_ST_DECEL) ? decel_act(sel) : post_act(sel);
      r_d.cmd.err_hold        = holds_err(sel);                     // see RULE_07, RULE_15
      r_d.cmd.err_clear       = !holds_err(sel);
      r_d.cmd.torque_limit_en = r_d.st == SSS_ST_DECEL && sel >= SSS_SEL_IMM_DB
                                && tq != 10'h000;                   // see RULE_08, RULE_20
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      r_q <= '0;
      // Shadow settings outlive a plain reset; only power-on restores defaults; speed threshold resets always
      r_q.shadow <= POWER_ON_N ? r_q.shadow : {SSS_RST_LIMIT_SEL, SSS_RST_SOFF_SEL, SSS_RST_PLOSS_SEL,
                                               SSS_RST_UV_SEL, SSS_RST_ALARM_SEL, SSS_RST_IMM_TORQUE};
      r_q.speed_thr <= SSS_RST_SPEED_THR;
      r_q.cmd.act <= SSS_ACT_ZERO_T;
      // Sync stages start at idle pin level, no false event after reset
      r_q.s_son <= '1;
      r_q.s_pwr <= '1;
    end
    else
      r_q <= r_d;
  end

  assign S_AXI_AWREADY = !r_q.aw_got;
  assign S_AXI_WREADY  = !r_q.w_got;
  assign S_AXI_BVALID  = r_q.bvalid;
  assign S_AXI_BRESP   = r_q.bslverr ? 2'b10 : 2'b00;
  assign S_AXI_ARREADY = !r_q.rvalid;
  assign S_AXI_RVALID  = r_q.rvalid;
  assign S_AXI_RDATA   = r_q.rdata;
  assign S_AXI_RRESP   = r_q.rslverr ? 2'b10 : 2'b00;
  assign STOP_CMD      = r_q.cmd;
  assign STOP_STATE    = r_q.st;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_stop_sticks: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_09
    (r_q.st == SSS_ST_STOP && !slow && r_q.s_son[SSS_SYNC_STAGES-1] && r_q.s_pwr[SSS_SYNC_STAGES-1]
     && (r_q.s_fwd[SSS_SYNC_STAGES-1] || r_q.s_rev[SSS_SYNC_STAGES-1])) |=> r_q.st == SSS_ST_STOP)
    else $error("stop state left while event held");
  chk_limit_zero: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_02
    (r_q.st == SSS_ST_STOP && r_q.ev == SSS_EV_LIMIT) |-> (r_q.cmd.zero_fwd ^ r_q.cmd.zero_rev))
    else $error("limit stop without zero torque side");
  chk_limit_clear: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_04
    (r_q.st != SSS_ST_RUN && r_q.ev == SSS_EV_LIMIT) |-> r_q.cmd.err_clear == (r_q.active.limit_sel == 2'h2))
    else $error("limit error clear mismatch");
  chk_hold_code: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_07
    (r_q.st != SSS_ST_RUN && r_q.ev == SSS_EV_SOFF) |-> r_q.cmd.err_hold == (r_q.active.soff_sel inside {[4:7]}))
    else $error("servo-off hold mismatch");
  chk_imm_torque: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_20
    r_q.cmd.torque_limit_en |-> (r_q.cmd.act == SSS_ACT_IMM && r_q.cmd.torque_limit != 10'h000))
    else $error("torque limit without immediate stop");
  chk_uv_alarm: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_14
    (r_q.active.uv_sel && r_q.s_son[SSS_SYNC_STAGES-1] && !r_q.s_pwr[SSS_SYNC_STAGES-1])
    |=> (r_q.cmd.uv_alarm && r_q.cmd.use_alarm_sel))
    else $error("undervoltage alarm without alarm stop");
  chk_post_free: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_08
    (r_q.st == SSS_ST_STOP && r_q.ev == SSS_EV_SOFF && r_q.active.soff_sel == 4'h9) |-> r_q.cmd.act == SSS_ACT_FREE)
    else $error("code 9 not servo-free after stop");
  chk_bus_resp: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (r_q.aw_got && r_q.w_got && !r_q.bvalid) |=> S_AXI_BVALID)
    else $error("write response missing");

endmodule

// >>> dv/sss_far_model.sv
/*
  Far-side model: host controller, limit switches and motor speed feedback.
  Assumes the bench calls drive and brake; speed falls only while decelerating.
*/
`timescale 1ns/1ps
module sss_far_model
  import sss_pkg::*;
(
  input  wire logic               clock,
  input  sss_pkg::sss_state_t     stop_state,
  output logic                    fwd_limit,
  output logic                    rev_limit,
  output logic                    servo_on,
  output logic                    power_ok,
  output logic                    alarm,
  output logic signed [15:0]      speed
);
  int decay = 0;

  initial
  begin
    fwd_limit = 1'h0;
    rev_limit = 1'h0;
    servo_on  = 1'h1;
    power_ok  = 1'h1;
    alarm     = 1'h0;
    speed     = 16'sh03e8;
  end

  task automatic drive(input logic f, input logic r, input logic s, input logic p, input logic a,
                       input logic signed [15:0] sp);
    @(posedge clock);
    decay <= 0;
    fwd_limit <= f;
    rev_limit <= r;
    servo_on  <= s;
    power_ok  <= p;
    alarm     <= a;
    speed     <= sp;
  endtask

  // Large step is a prompt stop, step 1 a slow one
  task automatic brake(input int st);
    @(posedge clock);
    decay <= st;
  endtask

  // Axis stays at rest after a stop until the host drives it again
  always @(posedge clock)
    if (decay > 0 && stop_state == SSS_ST_DECEL)
      speed <= (speed > decay) ? speed - 16'(decay) : (speed < -decay) ? speed + 16'(decay) : 16'sh0000;
endmodule

// >>> dv/tb_top.sv
/*
  Bench for sss_top: AXI4-Lite tasks and stop sequence cases.
  Assumes sss_far_model drives limit, servo, power, alarm and speed pins.
*/
`timescale 1ns/1ps
module tb_top;
  import sss_pkg::*;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic               CLOCK;
  logic               RST_N = 1'h0;
  logic               POWER_ON_N = 1'h0;
  logic [7:0]         S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0]        S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0]         S_AXI_WSTRB = 4'hf;
  logic [1:0]         S_AXI_BRESP, S_AXI_RRESP;
  logic               S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic               S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic               S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic               FORWARD_LIMIT_INPUT, REVERSE_LIMIT_INPUT, SERVO_ON_INPUT, MAIN_POWER_OK, ALARM_ACTIVE;
  logic signed [15:0] MOTOR_SPEED;
  sss_cmd_t           STOP_CMD;
  sss_state_t         STOP_STATE;
  sss_act_t           dec;
  sss_act_t           post;
  logic               held;
  int                 failures = 0;
  int                 n_checks = 0;

  sss_top i_dut (.CLOCK, .RST_N, .POWER_ON_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .FORWARD_LIMIT_INPUT, .REVERSE_LIMIT_INPUT, .SERVO_ON_INPUT,
    .MAIN_POWER_OK, .ALARM_ACTIVE, .MOTOR_SPEED, .STOP_CMD, .STOP_STATE);

  sss_far_model i_far (.clock(CLOCK), .stop_state(STOP_STATE), .fwd_limit(FORWARD_LIMIT_INPUT),
    .rev_limit(REVERSE_LIMIT_INPUT), .servo_on(SERVO_ON_INPUT), .power_ok(MAIN_POWER_OK),
    .alarm(ALARM_ACTIVE), .speed(MOTOR_SPEED));

  initial
  begin
    CLOCK = 1'h0;
    forever #2 CLOCK = ~CLOCK;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic got = 1'h0;
    int   n   = 0;
    @(posedge CLOCK);
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID  <= 1'h1;
    S_AXI_BREADY  <= 1'h1;
    while (!got && n < 100)
    begin
      @(posedge CLOCK);
      n++;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WVALID && S_AXI_WREADY)
        S_AXI_WVALID <= 1'h0;
      got = (S_AXI_BVALID === 1'h1);
    end
    S_AXI_BREADY <= 1'h0;
    chk("bvalid", 32'h1, got);
    chk("bresp", 32'h0, {30'h0, S_AXI_BRESP});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic got = 1'h0;
    int   n   = 0;
    @(posedge CLOCK);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY  <= 1'h1;
    while (!got && n < 100)
    begin
      @(posedge CLOCK);
      n++;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'h0;
      got = (S_AXI_RVALID === 1'h1);
    end
    S_AXI_RREADY <= 1'h0;
    chk("rvalid", 32'h1, got);
    chk("rdata", e, S_AXI_RDATA);
    chk("rresp", {30'h0, er}, {30'h0, S_AXI_RRESP});
  endtask

  // Settings load only on release of reset
  task automatic power_cycle();
    @(posedge CLOCK);
    RST_N <= 1'h0;
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'h1;
  endtask

  task automatic settle(input sss_state_t s);
    int n = 0;
    while (STOP_STATE !== s && n < 1000)
    begin
      @(negedge CLOCK);
      n++;
    end
    repeat (2) @(negedge CLOCK);
    chk("stop_state", s, STOP_STATE);
  endtask

  task automatic ev(input sss_state_t s, input sss_act_t a, input logic h);
    settle(s);
    chk("act", a, STOP_CMD.act);
    chk("err_clear", !h, STOP_CMD.err_clear);
    chk("err_hold", h, STOP_CMD.err_hold);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'h1;
    POWER_ON_N <= 1'h1;
    rd_chk(SSS_OFF_LIMIT_SEL, 32'h0, 2'h0);
    rd_chk(SSS_OFF_SOFF_SEL, 32'h0, 2'h0);
    rd_chk(SSS_OFF_PLOSS_SEL, 32'h0, 2'h0);
    rd_chk(SSS_OFF_UV_SEL, 32'h1, 2'h0);
    rd_chk(8'h40, 32'h0, 2'h2);
    wr(SSS_OFF_IMM_TORQUE, 32'h64);
    for (int l = 0; l < 3; l++)
    begin
      wr(SSS_OFF_LIMIT_SEL, l);
      power_cycle();
      i_far.drive(l != 1, l == 1, 1'h1, 1'h1, 1'h0, 16'sh03e8);
      dec = (l == 0) ? SSS_ACT_DBRAKE : (l == 1) ? SSS_ACT_ZERO_T : SSS_ACT_IMM;
      ev(SSS_ST_DECEL, dec, l != 2);
      if (l == 2)
        chk("torque_limit", 32'h64, STOP_CMD.torque_limit);
      i_far.brake(3);
      ev(SSS_ST_STOP, SSS_ACT_ZERO_T, l != 2);
      chk("zero_fwd", l != 1, STOP_CMD.zero_fwd);
      chk("zero_rev", l == 1, STOP_CMD.zero_rev);
      i_far.drive(l != 1, l == 1, 1'h1, 1'h1, 1'h0, 16'sh01f4);
      settle(SSS_ST_STOP);
      i_far.drive(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 16'sh03e8);
      settle(SSS_ST_RUN);
    end
    for (int k = 0; k < 2; k++)
      for (int v = 0; v < 10; v++)
      begin
        wr(SSS_OFF_SOFF_SEL, k ? 9 - v : v);
        wr(SSS_OFF_PLOSS_SEL, k ? v : 9 - v);
        wr(SSS_OFF_UV_SEL, 32'h0);
        power_cycle();
        i_far.drive(1'h0, 1'h0, 1'h0, k == 0, 1'h0, (v % 2) ? -16'sh00c8 : 16'sh00c8);
        dec  = (v > 7) ? SSS_ACT_IMM : (v % 2) ? SSS_ACT_FREE : SSS_ACT_DBRAKE;
        post = (v == 8) ? SSS_ACT_DBRAKE : (v == 9 || (v / 2) % 2) ? SSS_ACT_FREE : SSS_ACT_DBRAKE;
        held = (v >= 4 && v <= 7);
        ev(SSS_ST_DECEL, dec, held);
        if (v > 7)
          chk("torque_limit", 32'h64, STOP_CMD.torque_limit);
        i_far.brake(v + 1);
        ev(SSS_ST_STOP, post, held);
        i_far.drive(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 16'sh03e8);
        settle(SSS_ST_RUN);
      end
    wr(SSS_OFF_SOFF_SEL, 32'h7);
    i_far.drive(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 16'sh03e8);
    ev(SSS_ST_DECEL, SSS_ACT_DBRAKE, 1'h0);
    i_far.drive(1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 16'sh03e8);
    repeat (6) @(negedge CLOCK);
    chk("use_alarm_sel", 32'h1, STOP_CMD.use_alarm_sel);
    i_far.drive(1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 16'sh03e8);
    repeat (6) @(negedge CLOCK);
    chk("use_alarm_sel", 32'h1, STOP_CMD.use_alarm_sel);
    wr(SSS_OFF_UV_SEL, 32'h1);
    power_cycle();
    i_far.drive(1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 16'sh03e8);
    settle(SSS_ST_DECEL);
    chk("uv_alarm", 32'h1, STOP_CMD.uv_alarm);
    chk("use_alarm_sel", 32'h1, STOP_CMD.use_alarm_sel);
    finish_test();
  end

  // Whole run is near 3000 cycles; this span leaves ample margin
  initial
  begin
    repeat (60000) @(posedge CLOCK);
    failures++;
    finish_test();
  end
endmodule
